// ===== shared/ums_defines.svh
`ifndef UMS_DEFINES_SVH
`define UMS_DEFINES_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define UMS_OFF_DATA 12'h000
`define UMS_OFF_STAT_A 12'h004
`define UMS_OFF_CTRL_B 12'h008
`define UMS_OFF_CTRL_C 12'h00C
`define UMS_OFF_RATE_LO 12'h010
`define UMS_OFF_RATE_HI 12'h014

// ----------------------------------------
// field positions
// ----------------------------------------
`define UMS_B_RXEN 4
`define UMS_B_TXEN 3
`define UMS_C_MODE_HI 7
`define UMS_C_MODE_LO 6
`define UMS_C_LSB 2
`define UMS_C_PHA 1
`define UMS_C_POL 0
`define UMS_A_RXC 7
`define UMS_A_TXC 6
`define UMS_A_UDRE 5

// ----------------------------------------
// reset values and sizes
// ----------------------------------------
`define UMS_CTRL_B_RST 8'h06
`define UMS_CTRL_B_FIXED 3'h6
`define UMS_CTRL_C_RST 8'h06
`define UMS_RATE_RST 12'h000
`define UMS_RX_DEPTH 16
`define UMS_BITS_PER_FRAME 4'h8

`endif

// ===== shared/ums_pkg.sv
package ums_pkg;

  typedef enum logic [1:0] {
    UMS_MODE_ASYNC = 2'b00,
    UMS_MODE_SYNC = 2'b01,
    UMS_MODE_RSVD = 2'b10,
    UMS_MODE_MSPI = 2'b11
  } ums_mode_t;

  typedef enum logic [1:0] {
    UMS_ST_IDLE = 2'b00,
    UMS_ST_LEAD = 2'b01,
    UMS_ST_TRAIL = 2'b10
  } ums_state_t;

endpackage

// ===== hw/ums_fifo.sv
`timescale 1ns/10ps

module ums_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic do_wr;
  logic do_rd;

  assign in_ready = (count_r != DEPTH[AW:0]);
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rd_ptr_r];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  always_ff @(posedge pclk) begin
    if (do_wr) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // ----------------------------------------
  // pointers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else if (flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count_r <= count_r + 1'b1;
      end else if (do_rd && !do_wr) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule

// ===== hw/ums_master_spi.sv
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "ums_defines.svh"

// How it works
// - with rx_path_on set in master spi mode the block owns the serial input pin.
// - clearing rx_path_on flushes every unread byte from the receive buffer.
// - with tx_path_on set in master spi mode the block drives the serial output pin.
// - clearing tx_path_on takes effect only once the shifter and the buffer are empty.
// - mode field bits 7:6 select async, sync, reserved or master spi.
// - bit order, phase and polarity are taken in the same write that selects the mode.
// - bit 2 set shifts lsb first, clear shifts msb first.
// - bit 1 chooses sampling on the leading or the trailing clock edge.
// - bit 0 sets the idle clock level and with phase fixes the shift timing.
// - the rate divider sets the transfer clock as in normal serial operation.
// - a transfer begins when software writes the data register.
// - on receive overflow the newest byte is dropped and older bytes kept.
// - frame, overrun and parity flags read as zero in master spi mode.

module ums_master_spi (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_oe,
  output logic transfer_clock_pin,
  output logic transfer_clock_oe,
  output logic serial_in_owned
);

  logic [7:0] ctrl_b_r;
  logic [7:0] ctrl_c_r;
  logic [11:0] rate_r;
  logic [7:0] tx_buf_r;
  logic tx_full_r;
  logic [7:0] shift_r;
  logic [7:0] rx_shift_r;
  logic [3:0] bit_cnt_r;
  logic [11:0] div_cnt_r;
  logic sck_r;
  logic mosi_r;
  logic txc_r;
  logic tx_drive_r;
  ums_pkg::ums_state_t state_r;
  ums_pkg::ums_state_t state_nxt;
  logic wr_en;
  logic rd_en;
  logic mspi;
  logic rx_on;
  logic tx_on;
  logic lsb_first;
  logic cpha;
  logic cpol;
  logic tick;
  logic busy;
  logic load;
  logic last_half;
  logic rx_push;
  logic rx_in_ready;
  logic rx_valid;
  logic rx_pop;
  logic [7:0] rx_data;
  logic sample_bit;

  // out bit of a frame, respecting the chosen order
  function automatic logic out_bit(input logic [7:0] v, input logic lsb);
    out_bit = lsb ? v[0] : v[7];
  endfunction

  // shift a frame by one, bringing a new bit in at the far end
  function automatic logic [7:0] shift8(input logic [7:0] v, input logic lsb, input logic b);
    shift8 = lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  // mode field decode
  assign mspi = (ctrl_c_r[`UMS_C_MODE_HI:`UMS_C_MODE_LO] == ums_pkg::UMS_MODE_MSPI);
  assign rx_on = ctrl_b_r[`UMS_B_RXEN];
  assign tx_on = ctrl_b_r[`UMS_B_TXEN];
  assign lsb_first = ctrl_c_r[`UMS_C_LSB];
  assign cpha = ctrl_c_r[`UMS_C_PHA];
  assign cpol = ctrl_c_r[`UMS_C_POL];
  assign busy = (state_r != ums_pkg::UMS_ST_IDLE);

  assign serial_in_owned = mspi && rx_on;

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  // fields taken whole in one write, mode and format together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_b_r <= `UMS_CTRL_B_RST;
      ctrl_c_r <= `UMS_CTRL_C_RST;
      rate_r <= `UMS_RATE_RST;
    end else if (wr_en) begin
      if (paddr == `UMS_OFF_CTRL_B) begin
        // reserved low bits kept at their fixed value
        ctrl_b_r <= {3'h0, pwdata[4:3], `UMS_CTRL_B_FIXED};
      end else if (paddr == `UMS_OFF_CTRL_C) begin
        ctrl_c_r <= {pwdata[7:6], 3'h0, pwdata[2:0]};
      end else if (paddr == `UMS_OFF_RATE_LO) begin
        rate_r[7:0] <= pwdata[7:0];
      end else if (paddr == `UMS_OFF_RATE_HI) begin
        rate_r[11:8] <= pwdata[3:0];
      end
    end
  end

  // ----------------------------------------
  // transmit buffer
  // ----------------------------------------
  // data write starts a transfer; buffer then feeds the shifter
  // a byte still pending after disable is sent before release
  assign load = mspi && (tx_on || tx_drive_r) && tx_full_r && !busy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buf_r <= 8'h00;
      tx_full_r <= 1'b0;
    end else if (wr_en && paddr == `UMS_OFF_DATA && !tx_full_r) begin
      // writes while full are dropped; poll the empty flag first
      tx_buf_r <= pwdata[7:0];
      tx_full_r <= 1'b1;
    end else if (load) begin
      tx_full_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // baud divider
  // ----------------------------------------
  // half clock period is rate+1 system cycles
  assign tick = busy && (div_cnt_r == rate_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_r <= 12'h000;
    end else if (!busy || tick) begin
      div_cnt_r <= 12'h000;
    end else begin
      div_cnt_r <= div_cnt_r + 12'h001;
    end
  end

  // ----------------------------------------
  // shift engine
  // ----------------------------------------
  assign last_half = (state_r == ums_pkg::UMS_ST_TRAIL) && (bit_cnt_r == `UMS_BITS_PER_FRAME - 4'h1);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ums_pkg::UMS_ST_IDLE: begin
        if (load) begin
          state_nxt = ums_pkg::UMS_ST_LEAD;
        end
      end
      ums_pkg::UMS_ST_LEAD: begin
        if (tick) begin
          state_nxt = ums_pkg::UMS_ST_TRAIL;
        end
      end
      ums_pkg::UMS_ST_TRAIL: begin
        if (tick) begin
          state_nxt = last_half ? ums_pkg::UMS_ST_IDLE : ums_pkg::UMS_ST_LEAD;
        end
      end
      default: begin
        state_nxt = ums_pkg::UMS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ums_pkg::UMS_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // leading edge samples when phase clear, trailing edge when set
  assign sample_bit = tick && ((state_r == ums_pkg::UMS_ST_LEAD) ^ cpha);

  // eight bits out and eight in per frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_r <= 8'h00;
      rx_shift_r <= 8'h00;
      bit_cnt_r <= 4'h0;
      mosi_r <= 1'b1;
    end else if (load) begin
      shift_r <= tx_buf_r;
      bit_cnt_r <= 4'h0;
      // first bit chosen by order; phase 0 presents it before the first edge
      mosi_r <= out_bit(tx_buf_r, lsb_first);
    end else if (tick) begin
      if (sample_bit) begin
        rx_shift_r <= shift8(rx_shift_r, lsb_first, serial_in_pin);
      end
      if (state_r == ums_pkg::UMS_ST_TRAIL) begin
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
      if (!sample_bit) begin
        // output changes on the edge that does not sample; phase 1 already shows bit one
        if (cpha && state_r == ums_pkg::UMS_ST_LEAD && bit_cnt_r == 4'h0) begin
          mosi_r <= out_bit(shift_r, lsb_first);
        end else begin
          shift_r <= shift8(shift_r, lsb_first, 1'b0);
          mosi_r <= out_bit(shift8(shift_r, lsb_first, 1'b0), lsb_first);
        end
      end
    end
  end

  // idle level from polarity, each tick inverts it during a frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_r <= 1'b0;
    end else if (!busy) begin
      sck_r <= cpol;
    end else if (tick) begin
      sck_r <= ~sck_r;
    end
  end

  // ----------------------------------------
  // pin ownership and status
  // ----------------------------------------
  // output released only after shifter and buffer drain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_drive_r <= 1'b0;
    end else if (mspi && tx_on) begin
      tx_drive_r <= 1'b1;
    end else if (!busy && !tx_full_r) begin
      tx_drive_r <= 1'b0;
    end
  end

  // output pin driven while transmitter owns it
  assign serial_out_oe = tx_drive_r;
  assign transfer_clock_oe = tx_drive_r;
  assign serial_out_pin = mosi_r;
  assign transfer_clock_pin = sck_r;

  // transmit complete: set wins over a clear by writing one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txc_r <= 1'b0;
    end else if (tick && last_half && !tx_full_r) begin
      txc_r <= 1'b1;
    end else if (wr_en && paddr == `UMS_OFF_STAT_A && pwdata[`UMS_A_TXC]) begin
      txc_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // receive buffer
  // ----------------------------------------
  // push refused when full, so the newest byte is the one lost
  assign rx_push = tick && last_half && rx_on && rx_in_ready;
  assign rx_pop = rd_en && (paddr == `UMS_OFF_DATA);

  ums_fifo #(
    .WIDTH(8),
    .DEPTH(`UMS_RX_DEPTH)
  ) u_rx_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .flush(!rx_on),
    .in_valid(rx_push),
    .in_ready(rx_in_ready),
    .in_data(sample_bit ? shift8(rx_shift_r, lsb_first, serial_in_pin) : rx_shift_r),
    .out_valid(rx_valid),
    .out_ready(rx_pop),
    .out_data(rx_data)
  );

  // ----------------------------------------
  // read data
  // ----------------------------------------
  // error flag bits 4:2 always read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == `UMS_OFF_DATA) begin
        prdata <= {24'h000000, rx_valid ? rx_data : 8'h00};
      end else if (paddr == `UMS_OFF_STAT_A) begin
        prdata <= {24'h000000, rx_valid, txc_r, !tx_full_r, 5'h00};
      end else if (paddr == `UMS_OFF_CTRL_B) begin
        prdata <= {24'h000000, ctrl_b_r};
      end else if (paddr == `UMS_OFF_CTRL_C) begin
        prdata <= {24'h000000, ctrl_c_r};
      end else if (paddr == `UMS_OFF_RATE_LO) begin
        prdata <= {24'h000000, rate_r[7:0]};
      end else if (paddr == `UMS_OFF_RATE_HI) begin
        prdata <= {28'h0000000, rate_r[11:8]};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule

// ===== verification/ums_master_spi_chk.sv
`timescale 1ns/10ps
// ----------------------------------------
// port checks
// ----------------------------------------
module ums_master_spi_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_in_pin,
  input wire logic serial_out_pin,
  input wire logic serial_out_oe,
  input wire logic transfer_clock_pin,
  input wire logic transfer_clock_oe,
  input wire logic serial_in_owned
);
  logic [7:0] c_r;
  logic rx_r, tx_r;
  logic [11:0] rate_r, hp_cnt;
  wire wr = psel && penable && pwrite;
  wire rd = psel && penable && !pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c_r <= 8'h06;
      {rx_r, tx_r} <= 2'b00;
    end else if (wr && paddr == 12'h00C) begin
      c_r <= pwdata[7:0];
    end else if (wr && paddr == 12'h008) begin
      {rx_r, tx_r} <= pwdata[4:3];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_r <= 12'h000;
    end else if (wr && paddr == 12'h010) begin
      rate_r[7:0] <= pwdata[7:0];
    end else if (wr && paddr == 12'h014) begin
      rate_r[11:8] <= pwdata[3:0];
    end
  end
  // cycles since the clock pin last moved; saturates so idle gaps never wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hp_cnt <= 12'hFFF;
    end else if ($changed(transfer_clock_pin)) begin
      hp_cnt <= 12'h000;
    end else if (hp_cnt != 12'hFFF) begin
      hp_cnt <= hp_cnt + 12'h001;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_tx_wr;
    wr && paddr == 12'h008 && pwdata[3] && c_r[7:6] == 2'b11;
  endsequence
  sequence s_oe_up;
    ##[1:2] serial_out_oe;
  endsequence
  property p_tx_on; s_tx_wr |-> s_oe_up; endproperty
  a_tx_on: assert property (p_tx_on) else $error("output pin not taken");
  property p_oe_cause; $rose(serial_out_oe) |-> tx_r; endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("output taken without enable");
  property p_oe_pair; transfer_clock_oe == serial_out_oe; endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("clock enable differs");
  property p_owned; serial_in_owned == (c_r[7:6] == 2'b11 && rx_r); endproperty
  a_owned: assert property (p_owned) else $error("input ownership wrong");
  property p_ctrl_c; rd && paddr == 12'h00C |-> prdata[7:0] == {c_r[7:6], 3'b000, c_r[2:0]}; endproperty
  a_ctrl_c: assert property (p_ctrl_c) else $error("control c readback wrong");
  property p_ctrl_b; rd && paddr == 12'h008 |-> prdata[4:0] == {rx_r, tx_r, 3'b110}; endproperty
  a_ctrl_b: assert property (p_ctrl_b) else $error("control b readback wrong");
  property p_stat; rd && paddr == 12'h004 |-> prdata[4:0] == 5'h00 && prdata[31:8] == 24'h0; endproperty
  a_stat: assert property (p_stat) else $error("error flags not zero");
  property p_half; $changed(transfer_clock_pin) && serial_out_oe |-> hp_cnt >= rate_r; endproperty
  a_half: assert property (p_half) else $error("half period too short");
endmodule
bind ums_master_spi ums_master_spi_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .serial_in_pin(serial_in_pin),
  .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
  .transfer_clock_pin(transfer_clock_pin), .transfer_clock_oe(transfer_clock_oe),
  .serial_in_owned(serial_in_owned));

// ===== verification/ums_spi_slave.sv
`timescale 1ns/10ps
// ----------------------------------------
// spi slave model, no select line
// ----------------------------------------
module ums_spi_slave (
  input wire logic pclk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic pol,
  input wire logic pha,
  input wire logic lsb,
  output logic miso,
  output logic [7:0] rx_byte,
  output int frames
);
  logic s_r;
  logic [2:0] cnt;
  logic [7:0] sh, tx, nx;
  wire samp = (sclk != s_r) && ((sclk == pol) == pha);
  assign tx = 8'h30 + frames[7:0];
  // reply order; without a select the frame is framed by edge count only
  assign miso = lsb ? tx[cnt] : tx[3'd7 - cnt];
  assign nx = lsb ? {mosi, sh[7:1]} : {sh[6:0], mosi};
  always_ff @(posedge pclk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= pol;
      cnt <= 3'd0;
      sh <= 8'h00;
      rx_byte <= 8'h00;
      frames <= 0;
    end else begin
      s_r <= sclk;
      if (samp) begin
        sh <= nx;
        cnt <= cnt + 3'd1;
        if (cnt == 3'd7) begin
          rx_byte <= nx;
          frames <= frames + 1;
        end
      end
    end
  end
endmodule

// ===== verification/tb_ums_master_spi.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s expected %h seen %h", n, e, g); end end
module tb_ums_master_spi;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic sl_rst_n = 1'b0, pol = 1'b0, pha = 1'b0, lsb = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, miso, mosi, mosi_oe, sclk, sclk_oe, owned;
  logic [7:0] rx_byte;
  int frames, n, err_count = 0, samples_checked = 0;
  always #25 pclk = ~pclk;
  ums_master_spi dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_in_pin(miso), .serial_out_pin(mosi), .serial_out_oe(mosi_oe),
    .transfer_clock_pin(sclk), .transfer_clock_oe(sclk_oe), .serial_in_owned(owned));
  ums_spi_slave sl_u (.pclk(pclk), .rst_n(sl_rst_n), .sclk(sclk), .mosi(mosi), .pol(pol),
    .pha(pha), .lsb(lsb), .miso(miso), .rx_byte(rx_byte), .frames(frames));
  task final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task to_fail();
    err_count++;
    final_report();
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      if (++k > 50) to_fail();
    end while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_st(input int b);
    int k;
    k = 0;
    do begin
      apb(1'b0, 12'h004, 8'h00);
      if (++k > 400) to_fail();
    end while (q[b] !== 1'b1);
  endtask
  task send(input logic [7:0] d);
    wait_st(5);
    apb(1'b1, 12'h000, d);
  endtask
  task pulse_slave();
    @(posedge pclk) sl_rst_n <= 1'b0;
    @(posedge pclk) sl_rst_n <= 1'b1;
  endtask
  initial begin
    repeat (50000) @(posedge pclk);
    to_fail();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    sl_rst_n <= 1'b1;
    apb(1'b0, 12'h008, 8'h00);
    `CHK("ctrl_b", 32'h06, q)
    apb(1'b0, 12'h00C, 8'h00);
    `CHK("ctrl_c", 32'h06, q)
    apb(1'b0, 12'h004, 8'h00);
    `CHK("stat_a", 32'h20, q)
    apb(1'b0, 12'h018, 8'h00);
    `CHK("unmapped", 32'h0, q)
    $display("test reset done");
    apb(1'b1, 12'h010, 8'h01);
    for (int i = 0; i < 8; i++) begin
      {lsb, pha, pol} <= i[2:0];
      apb(1'b1, 12'h00C, {5'b11000, i[2:0]});
      apb(1'b1, 12'h008, 8'h18);
      pulse_slave();
      send(8'hC1 + 8'(i));
      wait_st(7);
      apb(1'b0, 12'h000, 8'h00);
      `CHK("rx data", 8'h30, q[7:0])
      `CHK("slave byte", 8'hC1 + 8'(i), rx_byte)
      wait_st(6);
      `CHK("idle clock", pol, sclk)
      apb(1'b1, 12'h004, 8'h40);
    end
    $display("test modes done");
    pulse_slave();
    for (int i = 0; i < 17; i++) send(8'h11);
    n = 0;
    while (frames != 17) begin
      @(posedge pclk);
      if (++n > 3000) to_fail();
    end
    wait_st(6);
    for (int i = 0; i < 16; i++) begin
      apb(1'b0, 12'h000, 8'h00);
      `CHK("fifo byte", 8'h30 + 8'(i), q[7:0])
    end
    apb(1'b0, 12'h004, 8'h40);
    `CHK("fifo empty", 1'b0, q[7])
    apb(1'b1, 12'h004, 8'h40);
    $display("test overflow done");
    send(8'h21);
    send(8'h22);
    wait_st(6);
    apb(1'b1, 12'h008, 8'h08);
    apb(1'b1, 12'h008, 8'h18);
    apb(1'b0, 12'h004, 8'h00);
    `CHK("flushed", 1'b0, q[7])
    $display("test flush done");
    pulse_slave();
    send(8'hA0);
    send(8'hA1);
    apb(1'b1, 12'h008, 8'h10);
    `CHK("oe held", 1'b1, mosi_oe)
    n = 0;
    while (mosi_oe === 1'b1) begin
      @(posedge pclk);
      if (++n > 2000) to_fail();
    end
    `CHK("frames done", 2, frames)
    `CHK("last byte", 8'hA1, rx_byte)
    $display("test shutdown done");
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, 12'h00C, {m[1:0], 6'h06});
      apb(1'b1, 12'h008, 8'h18);
      pulse_slave();
      apb(1'b1, 12'h000, 8'h77);
      repeat (100) @(posedge pclk);
      `CHK("no frame", 0, frames)
      `CHK("input free", 1'b0, owned)
    end
    $display("test async mode done");
    final_report();
  end
endmodule
